// ---- inc/mcp_pkg.sv ----
package mcp_pkg;

	// Frame geometry, counted in octets as delivered by the MAC with the FCS already stripped.
	localparam int MIN_FRAME_BITS   = 512;
	localparam int CTRL_FRAME_BYTES = (MIN_FRAME_BITS - 32) / 8;
	localparam int PARAM_MAX_BYTES  = (MIN_FRAME_BITS - 160) / 8;
	localparam int HDR_BYTES        = 16;

	// Byte counter used for positions inside a received frame.
	localparam int CNT_W = 11;
	typedef logic [CNT_W-1:0] mcp_cnt_t;
	localparam mcp_cnt_t LEN_MAX = 11'h7FF;

	// Field offsets in the order destination, source, type, opcode, parameters.
	localparam mcp_cnt_t OFS_DST    = 11'h000;
	localparam mcp_cnt_t OFS_SRC    = 11'h006;
	localparam mcp_cnt_t OFS_TYPE   = 11'h00C;
	localparam mcp_cnt_t OFS_TYPE_L = 11'h00D;
	localparam mcp_cnt_t OFS_OPC    = 11'h00E;
	localparam mcp_cnt_t OFS_OPC_L  = 11'h00F;
	localparam mcp_cnt_t OFS_PARAM  = 11'h010;
	localparam mcp_cnt_t CTRL_LEN   = mcp_cnt_t'(CTRL_FRAME_BYTES);

	// Type value that marks a control frame, and the group bit of an address.
	localparam logic [15:0] CTRL_TYPE   = 16'h8808;
	localparam int          GROUP_BIT   = 40;
	localparam logic [15:0] OPC_DEFAULT = 16'h0001;

	// Widths, reset values and the counter's saturation value.
	localparam int          STAT_W      = 2;
	localparam int          ADDR_W      = 48;
	localparam logic [7:0]  PAD_BYTE    = 8'h00;
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [15:0] CNT_SAT     = 16'hFFFF;

	// Receive machine states; header differs by one bit from each of idle, data and control.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HDR  = 3'b001,
		ST_DATA = 3'b011,
		ST_CTRL = 3'b101,
		ST_SKIP = 3'b110
	} mcp_state_e;

endpackage

// ---- inc/mcp_rx_if.sv ----
`timescale 1ns/10ps
interface mcp_rx_if;
	import mcp_pkg::*;

	// Byte feed from the receive machine into the header store.
	logic                  valid;
	logic [7:0]            data;
	mcp_cnt_t              idx;
	// Fields read back from the header store.
	logic [ADDR_W-1:0]     dst;
	logic [ADDR_W-1:0]     src;
	logic [15:0]           ltype_now;
	logic [15:0]           opcode;

	modport feed (output valid, data, idx, input dst, src, ltype_now, opcode);
	modport cap  (input valid, data, idx, output dst, src, ltype_now, opcode);
endinterface

// ---- hdl/mcp_hdr_cap.sv ----
`timescale 1ns/10ps
module mcp_hdr_cap
	import mcp_pkg::*;
(
	// Clock and reset.
	input  wire logic sys_clk_in,
	input  wire logic resetn_in,
	// Byte feed and captured fields.
	mcp_rx_if.cap     rif
);
	import mcp_pkg::*;

	logic [HDR_BYTES-1:0][7:0] hdr_ff;

	// Each header byte lands at its own position, so fields never need shifting.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			hdr_ff <= '0;
		else if (rif.valid && rif.idx < mcp_cnt_t'(HDR_BYTES))
			hdr_ff[rif.idx[3:0]] <= rif.data; // [RULE_23]
	end

	// First octet on the wire is the most significant octet of each field.
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			rif.dst[ADDR_W-1-8*i -: 8] = hdr_ff[int'(OFS_DST) + i]; // [RULE_02]
			rif.src[ADDR_W-1-8*i -: 8] = hdr_ff[int'(OFS_SRC) + i]; // [RULE_03]
		end
	end

	// The low type octet is taken straight from the feed so the decision costs no cycle.
	assign rif.ltype_now = {hdr_ff[OFS_TYPE[3:0]], rif.data}; // [RULE_04]
	// The low opcode octet is bypassed from the feed, so a frame ending on it is judged on its own opcode.
	assign rif.opcode    = {hdr_ff[OFS_OPC[3:0]],
		(rif.valid && rif.idx == OFS_OPC_L) ? rif.data : hdr_ff[OFS_OPC_L[3:0]]}; // [RULE_05] [RULE_14]
endmodule

// ---- hdl/mcp_opc_lookup.sv ----
`timescale 1ns/10ps
module mcp_opc_lookup #(
	parameter int          N_SUP    = 1,
	parameter logic [15:0] SUP_LIST [N_SUP] = '{mcp_pkg::OPC_DEFAULT}
) (
	// Opcode under test and the match result.
	input  wire logic [15:0] opcode_in,
	output logic             hit_out
);
	logic [N_SUP-1:0] match;

	// One comparator per supported opcode; any subset of opcodes may be built in.
	for (genvar g = 0; g < N_SUP; g++)
	begin : g_cmp
		assign match[g] = (opcode_in == SUP_LIST[g]); // [RULE_19]
	end

	assign hit_out = |match;
endmodule

// ---- hdl/mcp_rx_parser.sv ----
`timescale 1ns/10ps
// How it works
// (RULE_01) Control frames are handled at one fixed length, min frame less 32 bits.
// (RULE_02) Destination field is a 48-bit address, individual or group.
// (RULE_03) Source field is the sender's 48-bit individual address.
// (RULE_04) Type value 88-08 alone marks a control frame.
// (RULE_05) A control frame carries exactly one two-octet opcode.
// (RULE_06) Parameters are whole octets, zero up to min frame less 160 bits.
// (RULE_07) Unused space after the parameters is reserved and reads as zero.
// (RULE_08) Frames are requested from the MAC continuously; only valid frames arrive.
// (RULE_09) Any other type value makes a data frame, forwarded to the client.
// (RULE_10) Data indication copies addresses and status; payload is type then data.
// (RULE_11) A control frame of exact length with supported opcode starts its function; the code also requires an individual source address.
// (RULE_12) Longer supported control frames are either dropped or truncated and acted on.
// (RULE_13) Unsupported opcodes are dropped: not forwarded, not interpreted.
// (RULE_14) The opcode is the two octets right after the type field.
// (RULE_15) Drops for unsupported opcodes are flagged and counted for management.
// (RULE_16) A management enable gates reception of new frames.
// (RULE_17) The opcode function runs in parallel; parsing never waits for it.
// (RULE_18) A control indication is raised whenever the sublayer state changes.
// (RULE_19) Only a chosen subset of opcodes needs to be supported.
// (RULE_20) The client recovers lost, damaged or late frames itself.
// (RULE_21) The client may not assume the peer has this sublayer.
// (RULE_22) Control frames are always consumed here, never passed up as data.
// (RULE_23) Field order: destination, source, type, opcode, parameters, padding.
// (RULE_24) After each frame the machine returns to waiting for the next one.
module mcp_rx_parser #(
	parameter bit          TRUNC_LONG = 1'b1,
	parameter int          N_SUP      = 1,
	parameter logic [15:0] SUP_LIST [N_SUP] = '{mcp_pkg::OPC_DEFAULT},
	parameter int          FN_STATE_W = 8
) (
	// Clock and reset.
	input  wire logic                                       sys_clk_in,
	input  wire logic                                       resetn_in,
	// Receive byte stream from the MAC.
	input  wire logic                                       mac_valid_in,
	input  wire logic [7:0]                                 mac_byte_in,
	input  wire logic                                       mac_sof_in,
	input  wire logic                                       mac_eof_in,
	input  wire logic [mcp_pkg::STAT_W-1:0]                 mac_status_in,
	output logic                                            mac_req_out,
	// Management.
	input  wire logic                                       rx_enable_in,
	output logic                                            unsup_drop_out,
	output logic [15:0]                                     unsup_count_out,
	// Data indication to the client.
	output logic                                            dat_valid_out,
	output logic [7:0]                                      dat_byte_out,
	output logic                                            dat_sof_out,
	output logic                                            dat_eof_out,
	output logic [mcp_pkg::ADDR_W-1:0]                      dat_dst_out,
	output logic [mcp_pkg::ADDR_W-1:0]                      dat_src_out,
	output logic [mcp_pkg::STAT_W-1:0]                      dat_status_out,
	// Opcode function launch.
	output logic                                            fn_start_out,
	output logic [15:0]                                     fn_opcode_out,
	output logic [mcp_pkg::ADDR_W-1:0]                      fn_dst_out,
	output logic [mcp_pkg::ADDR_W-1:0]                      fn_src_out,
	output logic [mcp_pkg::PARAM_MAX_BYTES*8-1:0]           fn_params_out,
	// Control indication to the client.
	input  wire logic [FN_STATE_W-1:0]                      fn_state_in,
	output logic                                            ctl_ind_out,
	output logic [FN_STATE_W-1:0]                           ctl_state_out
);
	import mcp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	mcp_rx_if rif ();

	mcp_state_e                            state_ff;
	mcp_state_e                            nxt_state;
	mcp_state_e                            st_cur;
	mcp_cnt_t                              idx_ff;
	mcp_cnt_t                              cur_idx;
	mcp_cnt_t                              cur_len;
	logic                                  take;
	logic                                  is_ctrl;
	logic                                  decide;
	logic                                  fwd_now;
	logic                                  ctl_end;
	logic                                  opc_hit;
	logic                                  len_ok;
	logic                                  src_ok;
	logic                                  start_now;
	logic                                  unsup_now;
	logic [7:0]                            hold_ff;
	logic                                  flush_ff;
	logic [STAT_W-1:0]                     stat_ff;
	logic [PARAM_MAX_BYTES-1:0][7:0]       prm_ff;
	logic [PARAM_MAX_BYTES-1:0][7:0]       nxt_prm;
	logic                                  req_ff;
	logic                                  drop_ff;
	logic [15:0]                           cnt_ff;
	logic                                  dvalid_ff;
	logic [7:0]                            dbyte_ff;
	logic                                  dsof_ff;
	logic                                  deof_ff;
	logic [ADDR_W-1:0]                     ddst_ff;
	logic [ADDR_W-1:0]                     dsrc_ff;
	logic [STAT_W-1:0]                     dstat_ff;
	logic                                  fstart_ff;
	logic [15:0]                           fopc_ff;
	logic [ADDR_W-1:0]                     fdst_ff;
	logic [ADDR_W-1:0]                     fsrc_ff;
	logic [PARAM_MAX_BYTES*8-1:0]          fprm_ff;
	logic                                  ind_ff;
	logic [FN_STATE_W-1:0]                 cstate_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers: header store and opcode table.

	mcp_hdr_cap u_hdr (
		.sys_clk_in (sys_clk_in),
		.resetn_in  (resetn_in),
		.rif        (rif.cap)
	);

	mcp_opc_lookup #(
		.N_SUP    (N_SUP),
		.SUP_LIST (SUP_LIST)
	) u_opc (
		.opcode_in (rif.opcode),
		.hit_out   (opc_hit)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Byte position and receive machine.

	// The request never drops, so every valid byte offered by the MAC is taken.
	assign take    = mac_valid_in & req_ff; // [RULE_08]
	assign cur_idx = mac_sof_in ? OFS_DST : idx_ff;
	assign cur_len = (cur_idx == LEN_MAX) ? LEN_MAX : cur_idx + 11'h001;

	// A start of frame opens a new frame whatever the machine was doing.
	always_comb
	begin
		st_cur = state_ff;
		if (mac_sof_in)
			st_cur = rx_enable_in ? ST_HDR : ST_SKIP; // [RULE_16]
	end

	assign is_ctrl = (rif.ltype_now == CTRL_TYPE); // [RULE_04]
	assign decide  = take && (st_cur == ST_HDR) && (cur_idx == OFS_TYPE_L);
	assign fwd_now = (decide && !is_ctrl) || (take && st_cur == ST_DATA);

	// Next state: the type octets pick data or control, and every end of frame returns to idle.
	always_comb
	begin
		nxt_state = state_ff;
		if (take)
		begin
			unique case (st_cur)
				ST_IDLE: nxt_state = ST_IDLE;
				ST_HDR:  nxt_state = (cur_idx == OFS_TYPE_L) ? (is_ctrl ? ST_CTRL : ST_DATA) : ST_HDR; // [RULE_09]
				ST_DATA: nxt_state = ST_DATA;
				ST_CTRL: nxt_state = ST_CTRL;
				ST_SKIP: nxt_state = ST_SKIP;
				default: nxt_state = ST_IDLE;
			endcase
			if (mac_eof_in)
				nxt_state = ST_IDLE; // [RULE_24]
		end
	end

	// State register.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Byte counter, saturating so an oversize frame cannot wrap into a legal length.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			idx_ff <= OFS_DST;
		else if (take)
			idx_ff <= cur_len;
	end

	// Header store is fed during header and control bytes only.
	assign rif.valid = take && (st_cur == ST_HDR || st_cur == ST_CTRL);
	assign rif.data  = mac_byte_in;
	assign rif.idx   = cur_idx;

	// Continuous frame request to the MAC.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			req_ff <= 1'b0;
		else
			req_ff <= 1'b1; // [RULE_08]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data indication path.

	// One byte of delay lets the type octets lead the payload once the type is known.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			hold_ff <= PAD_BYTE;
		else if (take)
			hold_ff <= mac_byte_in;
	end

	// Receive status is kept from the last byte until the held byte drains.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			flush_ff <= 1'b0;
			stat_ff  <= '0;
		end
		else
		begin
			flush_ff <= fwd_now && mac_eof_in;
			if (take && mac_eof_in)
				stat_ff <= mac_status_in;
		end
	end

	// Payload starts with the type octets and then the frame data; control frames never get here.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			dvalid_ff <= 1'b0;
			dbyte_ff  <= PAD_BYTE;
			dsof_ff   <= 1'b0;
			deof_ff   <= 1'b0;
		end
		else
		begin
			dvalid_ff <= fwd_now || flush_ff; // [RULE_09] [RULE_22]
			dsof_ff   <= decide && !is_ctrl; // [RULE_10]
			deof_ff   <= flush_ff;
			if (fwd_now || flush_ff)
				dbyte_ff <= hold_ff; // [RULE_10]
		end
	end

	// Addresses and status travel with the indication.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ddst_ff  <= '0;
			dsrc_ff  <= '0;
			dstat_ff <= '0;
		end
		else
		begin
			if (decide && !is_ctrl)
			begin
				ddst_ff <= rif.dst; // [RULE_10]
				dsrc_ff <= rif.src;
			end
			if (flush_ff)
				dstat_ff <= stat_ff; // [RULE_10]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control frame path.

	// Parameter octets are cleared at each start, so octets never received read as zero padding.
	always_comb
	begin
		for (int i = 0; i < PARAM_MAX_BYTES; i++)
		begin
			if (take && mac_sof_in)
				nxt_prm[i] = PAD_BYTE; // [RULE_07]
			else if (take && st_cur == ST_CTRL && cur_idx == OFS_PARAM + mcp_cnt_t'(i))
				nxt_prm[i] = mac_byte_in; // [RULE_06]
			else
				nxt_prm[i] = prm_ff[i];
		end
	end

	// Parameter store.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			prm_ff <= '0;
		else
			prm_ff <= nxt_prm;
	end

	// End-of-frame verdict: exact length, or longer when truncation is built in.
	assign ctl_end   = take && mac_eof_in && (st_cur == ST_CTRL);
	assign len_ok    = (cur_len == CTRL_LEN) || (TRUNC_LONG && cur_len > CTRL_LEN); // [RULE_01] [RULE_12]
	assign src_ok    = !rif.src[GROUP_BIT]; // [RULE_03]
	assign start_now = ctl_end && len_ok && opc_hit && src_ok; // [RULE_11]
	assign unsup_now = ctl_end && !opc_hit && (cur_len > OFS_OPC_L); // [RULE_13]

	// Launch pulse with a frozen copy of the fields, so the function runs beside the parser.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			fstart_ff <= 1'b0;
			fopc_ff   <= 16'h0000;
			fdst_ff   <= '0;
			fsrc_ff   <= '0;
			fprm_ff   <= '0;
		end
		else
		begin
			fstart_ff <= start_now; // [RULE_17]
			if (start_now)
			begin
				fopc_ff <= rif.opcode; // [RULE_14]
				fdst_ff <= rif.dst;
				fsrc_ff <= rif.src;
				fprm_ff <= nxt_prm; // [RULE_12]
			end
		end
	end

	// Unsupported opcode drops are flagged and counted, saturating at the top.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			drop_ff <= 1'b0;
			cnt_ff  <= CNT_RST;
		end
		else
		begin
			drop_ff <= unsup_now; // [RULE_15]
			if (unsup_now && cnt_ff != CNT_SAT)
				cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// Any change of the function's state is echoed to the client with a pulse.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ind_ff    <= 1'b0;
			cstate_ff <= '0;
		end
		else
		begin
			ind_ff    <= (fn_state_in != cstate_ff); // [RULE_18]
			cstate_ff <= fn_state_in;
		end
	end

	// Outputs straight from flip-flops.
	assign mac_req_out     = req_ff;
	assign unsup_drop_out  = drop_ff;
	assign unsup_count_out = cnt_ff;
	assign dat_valid_out   = dvalid_ff;
	assign dat_byte_out    = dbyte_ff;
	assign dat_sof_out     = dsof_ff;
	assign dat_eof_out     = deof_ff;
	assign dat_dst_out     = ddst_ff;
	assign dat_src_out     = dsrc_ff;
	assign dat_status_out  = dstat_ff;
	assign fn_start_out    = fstart_ff;
	assign fn_opcode_out   = fopc_ff;
	assign fn_dst_out      = fdst_ff;
	assign fn_src_out      = fsrc_ff;
	assign fn_params_out   = fprm_ff;
	assign ctl_ind_out     = ind_ff;
	assign ctl_state_out   = cstate_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);

	chk_req_steady: assert property (req_ff |=> mac_req_out [*3]) // [RULE_08]
		else $error("Frame request dropped.");

	chk_ctrl_sunk: assert property (decide && is_ctrl |=> !dat_sof_out ##1 !dat_sof_out) // [RULE_22]
		else $error("Control frame started a data indication.");

	chk_data_start: assert property (decide && !is_ctrl |=> dat_valid_out && dat_sof_out
		&& dat_byte_out == $past(hold_ff) && dat_dst_out == $past(rif.dst)) // [RULE_10]
		else $error("Data indication did not start with the type octet.");

	chk_data_tail: assert property (fwd_now && mac_eof_in |=> ##1 dat_valid_out && dat_eof_out
		&& dat_status_out == $past(mac_status_in, 2)) // [RULE_10]
		else $error("Data indication end or status wrong.");

	chk_ctrl_len: assert property (ctl_end && cur_len != CTRL_LEN && !(TRUNC_LONG && cur_len > CTRL_LEN)
		|=> !fn_start_out) // [RULE_01]
		else $error("Control frame of wrong length launched a function.");

	chk_unsup_drop: assert property (ctl_end && !opc_hit && cur_len > OFS_OPC_L
		|=> unsup_drop_out && !fn_start_out) // [RULE_13]
		else $error("Unsupported opcode not dropped.");

	chk_drop_count: assert property (unsup_drop_out && $past(cnt_ff) != CNT_SAT
		|-> unsup_count_out == $past(cnt_ff) + 16'h0001) // [RULE_15]
		else $error("Drop counter did not step.");

	chk_launch_fields: assert property (start_now |=> fn_start_out && fn_opcode_out == $past(rif.opcode)) // [RULE_14]
		else $error("Launch opcode does not match the frame.");

	chk_skip_quiet: assert property (take && mac_sof_in && !rx_enable_in && !mac_eof_in
		|=> state_ff == ST_SKIP ##1 !fn_start_out) // [RULE_16]
		else $error("Frame taken while reception disabled.");

	chk_ind_change: assert property ($changed(ctl_state_out) |-> ctl_ind_out) // [RULE_18]
		else $error("State change without control indication.");

	chk_idle_return: assert property (take && mac_eof_in |=> state_ff == ST_IDLE) // [RULE_24]
		else $error("Machine did not return to idle.");

	cov_data_frame: cover property (dat_sof_out ##[1:100] dat_eof_out);
	cov_launch:     cover property (fn_start_out);
	cov_unsup:      cover property (unsup_drop_out);
	cov_back2back:  cover property (fn_start_out ##[1:80] dat_sof_out);
endmodule

// ---- tb/mcp_mac_model.sv ----
`timescale 1ns/10ps
module mcp_mac_model
(
	// Clock and frame request.
	input  wire logic                      sys_clk_in,
	input  wire logic                      mac_req_in,
	// Receive byte stream.
	output logic                           valid_out,
	output logic [7:0]                     byte_out,
	output logic                           sof_out,
	output logic                           eof_out,
	output logic [mcp_pkg::STAT_W-1:0]     status_out
);
	import mcp_pkg::*;

	// Idle line at time zero.
	initial
	begin
		valid_out = 1'b0;
		byte_out = 8'h00;
		sof_out = 1'b0;
		eof_out = 1'b0;
		status_out = '0;
	end

	// Octet k of a test frame, fields in wire order.
	function automatic logic [7:0] fbyte(input int k, input logic [15:0] typ, input logic [15:0] opc, input bit grp);
		if (k < 6)
			return 8'h10 + 8'(k);                  // Individual destination.
		if (k < 12)
			return (8'h20 + 8'(k - 6)) | {7'h00, grp && k == 6}; // Source, group bit only on request.
		if (k < 14)
			return (k == 12) ? typ[15:8] : typ[7:0]; // Type field.
		if (k < 16)
			return (k == 14) ? opc[15:8] : opc[7:0]; // One opcode.
		return 8'(k);                              // Whole parameter octets.
	endfunction

	// Offers a whole frame, one octet a cycle, keeping the line for a following frame.
	task automatic send(input int len, input logic [15:0] typ, input logic [15:0] opc, input logic [1:0] st,
		input bit grp);
		int k;
		while (mac_req_in !== 1'b1)
			@(posedge sys_clk_in);
		for (k = 0; k < len; k++)
		begin
			@(posedge sys_clk_in);
			valid_out <= 1'b1;
			byte_out <= fbyte(k, typ, opc, grp);
			sof_out <= (k == 0);
			eof_out <= (k == len - 1);
			status_out <= (k == len - 1) ? st : ~st;
		end
	endtask

	// Releases the line; data lines show the inverse of their last value.
	task automatic idle();
		@(posedge sys_clk_in);
		valid_out <= 1'b0;
		sof_out <= 1'b0;
		eof_out <= 1'b0;
		byte_out <= ~byte_out;
		status_out <= ~status_out;
	endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import mcp_pkg::*;

	logic                          sys_clk_in = 1'b0;
	logic                          resetn_in = 1'b0;
	logic                          rx_enable_in = 1'b1;
	logic [7:0]                    fn_state_in = 8'h00;
	logic                          mac_valid_in, mac_sof_in, mac_eof_in, mac_req_out;
	logic [7:0]                    mac_byte_in, dat_byte_out, ctl_state_out;
	logic [STAT_W-1:0]             mac_status_in, dat_status_out, last_stat;
	logic                          dat_valid_out, dat_sof_out, dat_eof_out, fn_start_out, unsup_drop_out, ctl_ind_out;
	logic [15:0]                   unsup_count_out, fn_opcode_out;
	logic [ADDR_W-1:0]             dat_dst_out, dat_src_out, fn_dst_out, fn_src_out;
	logic [PARAM_MAX_BYTES*8-1:0]  fn_params_out;
	logic [7:0]                    pay[$];
	int                            error_cnt = 0, comparisons = 0, n_sof, n_eof, n_start, n_drop, n_ind;

	// 20 MHz clock.
	always #25 sys_clk_in = ~sys_clk_in;

	mcp_mac_model mcp_mac_model_i (.sys_clk_in(sys_clk_in), .mac_req_in(mac_req_out), .valid_out(mac_valid_in),
		.byte_out(mac_byte_in), .sof_out(mac_sof_in), .eof_out(mac_eof_in), .status_out(mac_status_in));

	mcp_rx_parser mcp_rx_parser_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .mac_valid_in(mac_valid_in),
		.mac_byte_in(mac_byte_in), .mac_sof_in(mac_sof_in), .mac_eof_in(mac_eof_in), .mac_status_in(mac_status_in),
		.mac_req_out(mac_req_out), .rx_enable_in(rx_enable_in), .unsup_drop_out(unsup_drop_out),
		.unsup_count_out(unsup_count_out), .dat_valid_out(dat_valid_out), .dat_byte_out(dat_byte_out),
		.dat_sof_out(dat_sof_out), .dat_eof_out(dat_eof_out), .dat_dst_out(dat_dst_out), .dat_src_out(dat_src_out),
		.dat_status_out(dat_status_out), .fn_start_out(fn_start_out), .fn_opcode_out(fn_opcode_out),
		.fn_dst_out(fn_dst_out), .fn_src_out(fn_src_out), .fn_params_out(fn_params_out), .fn_state_in(fn_state_in),
		.ctl_ind_out(ctl_ind_out), .ctl_state_out(ctl_state_out));

	// Collects every pulse and payload byte the parser emits.
	always @(posedge sys_clk_in)
	begin
		if (dat_valid_out === 1'b1)
			pay.push_back(dat_byte_out);
		if (dat_eof_out === 1'b1)
			last_stat = dat_status_out;
		n_sof += int'(dat_sof_out === 1'b1);
		n_eof += int'(dat_eof_out === 1'b1);
		n_start += int'(fn_start_out === 1'b1);
		n_drop += int'(unsup_drop_out === 1'b1);
		n_ind += int'(ctl_ind_out === 1'b1);
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask

	// Lets the last outputs land, off the edge; the tallies are cleared only by clr.
	task automatic settle();
		repeat (4) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic clr();
		pay.delete();
		{n_sof, n_eof, n_start, n_drop, n_ind} = '0;
	endtask

	task automatic summarize();
		$display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Data frame of 64 octets; opcode slots carry their own index.
	task automatic t_data();
		int i;
		clr();
		mcp_mac_model_i.send(64, 16'h0800, 16'h0E0F, 2'b10, 1'b0);
		mcp_mac_model_i.idle();
		settle();
		check(64'(pay.size()), 64'd52, "payload length");
		for (i = 0; i < pay.size(); i++)
			check(pay[i], (i == 0) ? 8'h08 : (i == 1) ? 8'h00 : 8'(i + 12), "payload byte");
		check(dat_dst_out, 48'h101112131415, "data dst");
		check(dat_src_out, 48'h202122232425, "data src");
		check(last_stat, 2'b10, "data status");
		check(64'(n_sof * 2 + n_eof + n_start * 8), 64'd3, "data framing");
	endtask

	// Supported control frame of the given length, with group or individual source.
	task automatic t_ctrl(input int len, input bit grp, input int starts);
		clr();
		mcp_mac_model_i.send(len, 16'h8808, 16'h0001, 2'b01, grp);
		mcp_mac_model_i.idle();
		settle();
		check(64'(n_start), 64'(starts), "launch count");
		check(64'(pay.size() + n_drop), 64'd0, "control frame leaked");
		check(fn_opcode_out, 16'h0001, "opcode");
		check(fn_params_out[7:0], 8'h10, "first param");
		check(fn_params_out[8*43+:8], 8'h3B, "last param");
		check(fn_dst_out, 48'h101112131415, "fn dst");
		check(fn_src_out, 48'h202122232425, "fn src");
	endtask

	// Unsupported opcode is counted, never launched nor forwarded.
	task automatic t_unsup();
		clr();
		mcp_mac_model_i.send(16, 16'h8808, 16'h0002, 2'b00, 1'b0);
		mcp_mac_model_i.send(60, 16'h8808, 16'h0002, 2'b00, 1'b0);
		mcp_mac_model_i.idle();
		settle();
		check(64'(n_drop), 64'd2, "drop pulse");
		check(unsup_count_out, 16'h0002, "drop count");
		check(64'(n_start + pay.size()), 64'd0, "unsupported acted on");
	endtask

	// Receive disabled: a data frame is ignored, then reception resumes.
	task automatic t_disable();
		@(posedge sys_clk_in);
		rx_enable_in <= 1'b0;
		clr();
		mcp_mac_model_i.send(64, 16'h0800, 16'h0E0F, 2'b10, 1'b0);
		mcp_mac_model_i.idle();
		settle();
		check(64'(pay.size()), 64'd0, "disabled receive");
		@(posedge sys_clk_in);
		rx_enable_in <= 1'b1;
	endtask

	// Control, data, control back to back; parsing never waits for a launch.
	task automatic t_b2b();
		clr();
		mcp_mac_model_i.send(60, 16'h8808, 16'h0001, 2'b00, 1'b0);
		mcp_mac_model_i.send(64, 16'h0800, 16'h0E0F, 2'b11, 1'b0);
		mcp_mac_model_i.send(60, 16'h8808, 16'h0001, 2'b00, 1'b0);
		mcp_mac_model_i.idle();
		settle();
		check(64'(n_start), 64'd2, "back to back launches");
		check(64'(pay.size()), 64'd52, "back to back data");
		check(last_stat, 2'b11, "back to back status");
	endtask

	// Function state change yields exactly one indication.
	task automatic t_ind();
		clr();
		@(posedge sys_clk_in);
		fn_state_in <= 8'h5A;
		settle();
		check(64'(n_ind), 64'd1, "indication pulses");
		check(ctl_state_out, 8'h5A, "indicated state");
	endtask

	// Main sequence.
	initial
	begin
		repeat (5) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		@(posedge sys_clk_in);
		#1;
		check(mac_req_out, 1'b1, "request after reset");
		t_data();
		t_ctrl(60, 1'b0, 1);
		t_ctrl(64, 1'b0, 1);
		t_ctrl(60, 1'b1, 0);
		t_unsup();
		t_disable();
		t_b2b();
		t_ind();
		check(mac_req_out, 1'b1, "request held");
		summarize();
	end

	// Watchdog well beyond the roughly 620 cycles of traffic.
	initial
	begin
		repeat (4000) @(posedge sys_clk_in);
		error_cnt++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		summarize();
	end
endmodule
